// >>> design/fcd_pkg.sv
/*
 * Shared constants and types of the flash command decoder: command codes,
 * status word bit positions, register map of the APB slave, reset values.
 * Assumes a single clock domain and a 32-bit APB with word-aligned access.
 */
package fcd_pkg;

    // Command codes written on the low byte of a command cycle.
    localparam logic [7:0] CODE_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CODE_READ_STATUS = 8'h70;
    localparam logic [7:0] CODE_READ_ID = 8'h90;
    localparam logic [7:0] CODE_READ_QUERY = 8'h98;
    localparam logic [7:0] CODE_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CODE_FACTORY_SETUP = 8'h80;
    localparam logic [7:0] CODE_CONFIRM = 8'hD0;
    localparam logic [7:0] CODE_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CODE_SUSPEND = 8'hB0;
    localparam logic [7:0] CODE_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CODE_LOCK = 8'h01;
    localparam logic [7:0] CODE_LOCK_DOWN = 8'h2F;
    localparam logic [7:0] CODE_PROT_SETUP = 8'hC0;
    localparam logic [7:0] CODE_SET_READ_SETUP = 8'h03;

    // Status word bit positions.
    localparam int SR_READY = 7;
    localparam int SR_ERASE_SUSP = 6;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_PROG_ERR = 4;
    localparam int SR_PROG_SUSP = 2;
    localparam logic [7:0] SR_ERR_MASK = 8'h3A;
    localparam logic [7:0] SR_SEQ_ERR = 8'h30;
    localparam logic [7:0] SR_RESET = 8'h80;

    // Read setup register: reset value and asynchronous read mode bit.
    localparam logic [15:0] RSR_RESET = 16'hBFCF;
    localparam int RSR_ASYNC_BIT = 15;

    // Per-block lock state: bit 0 locked, bit 1 locked down.
    localparam logic [1:0] LOCK_RESET = 2'h1;
    localparam logic [1:0] LOCK_LOCKED = 2'h1;
    localparam logic [1:0] LOCK_DOWN = 2'h3;
    localparam logic [1:0] LOCK_OPEN = 2'h0;

    // APB register byte offsets.
    localparam logic [7:0] OFF_CMD_ADDR = 8'h00;
    localparam logic [7:0] OFF_CMD_DATA = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_STATE = 8'h0C;
    localparam logic [7:0] OFF_READ_SETUP = 8'h10;
    localparam logic [7:0] OFF_LOCK = 8'h14;
    localparam logic [7:0] OFF_STATUS_OUT = 8'h18;

    typedef enum logic [1:0] {
        FCD_RD_ARRAY,
        FCD_RD_STATUS,
        FCD_RD_ID,
        FCD_RD_QUERY
    } fcd_read_state_t;

    typedef enum logic [1:0] {
        FCD_OP_NONE,
        FCD_OP_ERASE,
        FCD_OP_FACTORY,
        FCD_OP_PROT
    } fcd_op_t;

    // Work handed to the write state machine.
    typedef struct packed {
        fcd_op_t op;
        logic [31:0] addr;
        logic [15:0] data;
    } fcd_work_t;

endpackage

// >>> design/fcd_command_decoder.sv
/*
 * Command decoder of a parallel NOR flash: interprets two-cycle command
 * sequences, keeps the status word, block lock state and read setup register,
 * and hands accepted work to the write state machine.
 * Assumes command cycles arrive as APB writes, the write state machine runs
 * on pclk, and the chip select, output enable and address valid pins are
 * asynchronous and are synchronised here. presetn doubles as the reset pin.
 */
`timescale 1ns/1ps

module fcd_command_decoder #(
    parameter int ADDR_W = 32,
    parameter int BLK_LSB = 16,
    parameter int BLK_W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic address_valid_n,
    input wire logic wsm_done,
    input wire logic [7:0] wsm_err_bits,
    input wire logic wsm_suspend_ack,
    output fcd_pkg::fcd_work_t wsm_work,
    output logic wsm_start,
    output logic wsm_suspend,
    output logic wsm_resume,
    output fcd_pkg::fcd_read_state_t read_state,
    output logic [7:0] status_out,
    output logic [15:0] read_setup_register,
    output logic factory_mode
);

    typedef enum logic [3:0] {
        FCD_IDLE,
        FCD_FACTORY_SETUP,
        FCD_ERASE_SETUP,
        FCD_CFG_SETUP,
        FCD_PROT_SETUP,
        FCD_BUSY,
        FCD_SUSP_WAIT,
        FCD_SUSPENDED,
        FCD_FACTORY_MODE
    } fcd_state_t;

    localparam int NUM_BLOCKS = 1 << BLK_W;
    fcd_state_t state_reg, state_next;
    fcd_pkg::fcd_read_state_t rs_reg, rs_next;
    fcd_pkg::fcd_work_t work_reg, work_next;
    logic [7:0] sr_reg, sr_next;
    logic [7:0] sr_set, sr_clr;
    logic [15:0] rsr_reg, rsr_next;
    logic [ADDR_W-1:0] cmd_addr_reg;
    logic [15:0] cmd_data_reg;
    logic start_next, suspend_reg, suspend_next, resume_next;
    logic [1:0] lock_reg [NUM_BLOCKS];
    logic lock_we;
    logic [1:0] lock_wval;
    logic [7:0] status_out_reg;
    logic pready_reg, factory_mode_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    // APB decode: zero-wait slave, answer prepared in the setup cycle.
    wire logic apb_setup = psel & ~penable;
    wire logic apb_done = psel & penable & pready_reg;
    wire logic apb_wr = apb_done & pwrite;
    wire logic [7:0] reg_off = paddr[7:0];
    wire logic addr_hit_high = (paddr[31:8] == 24'h000000);
    wire logic hit_addr = addr_hit_high && reg_off == fcd_pkg::OFF_CMD_ADDR;
    wire logic hit_data = addr_hit_high && reg_off == fcd_pkg::OFF_CMD_DATA;
    wire logic hit_status = addr_hit_high && reg_off == fcd_pkg::OFF_STATUS;
    wire logic hit_state = addr_hit_high && reg_off == fcd_pkg::OFF_STATE;
    wire logic hit_rsr = addr_hit_high && reg_off == fcd_pkg::OFF_READ_SETUP;
    wire logic hit_lock = addr_hit_high && reg_off == fcd_pkg::OFF_LOCK;
    wire logic hit_sout = addr_hit_high && reg_off == fcd_pkg::OFF_STATUS_OUT;
    wire logic hit_any = hit_addr | hit_data | hit_status | hit_state |
        hit_rsr | hit_lock | hit_sout;

    // A write to the command data register is one bus write cycle.
    wire logic cmd_fire = apb_wr & hit_data;
    wire logic [7:0] code = pwdata[7:0];
    wire logic [BLK_W-1:0] blk = cmd_addr_reg[BLK_LSB +: BLK_W];
    wire logic [1:0] blk_lock = lock_reg[blk];

    wire logic [31:0] addr_word = 32'(cmd_addr_reg);
    wire logic [31:0] state_word = {24'h000000, state_reg,
        2'h0, rs_reg};
    wire logic [31:0] rd_mux =
        hit_addr ? addr_word :
        hit_data ? {16'h0000, cmd_data_reg} :
        hit_status ? {24'h000000, sr_reg} :
        hit_state ? state_word :
        hit_rsr ? {16'h0000, rsr_reg} :
        hit_lock ? {30'h00000000, blk_lock} :
        hit_sout ? {24'h000000, status_out_reg} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= apb_setup;
            pslverr_reg <= apb_setup & ~hit_any;
            prdata_reg <= (apb_setup & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_addr_reg <= '0;
            cmd_data_reg <= 16'h0000;
        end else begin
            if (apb_wr & hit_addr) begin
                cmd_addr_reg <= pwdata[ADDR_W-1:0];
            end
            if (cmd_fire) begin
                cmd_data_reg <= pwdata[15:0];
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        rs_next = rs_reg;
        work_next = work_reg;
        rsr_next = rsr_reg;
        sr_set = 8'h00;
        sr_clr = 8'h00;
        start_next = 1'b0;
        suspend_next = suspend_reg;
        resume_next = 1'b0;
        lock_we = 1'b0;
        lock_wval = blk_lock;
        unique case (state_reg)
            FCD_IDLE: begin
                if (cmd_fire) begin
                    unique case (code)
                        fcd_pkg::CODE_FACTORY_SETUP:
                            state_next = FCD_FACTORY_SETUP;
                        fcd_pkg::CODE_ERASE_SETUP:
                            state_next = FCD_ERASE_SETUP;
                        fcd_pkg::CODE_LOCK_SETUP:
                            state_next = FCD_CFG_SETUP;
                        fcd_pkg::CODE_PROT_SETUP:
                            state_next = FCD_PROT_SETUP;
                        fcd_pkg::CODE_READ_STATUS:
                            rs_next = fcd_pkg::FCD_RD_STATUS;
                        fcd_pkg::CODE_READ_ARRAY:
                            rs_next = fcd_pkg::FCD_RD_ARRAY;
                        fcd_pkg::CODE_READ_ID:
                            rs_next = fcd_pkg::FCD_RD_ID;
                        fcd_pkg::CODE_READ_QUERY:
                            rs_next = fcd_pkg::FCD_RD_QUERY;
                        fcd_pkg::CODE_CLEAR_STATUS:
                            sr_clr = fcd_pkg::SR_ERR_MASK;
                        default: ;
                    endcase
                end
            end
            FCD_FACTORY_SETUP: begin
                if (cmd_fire) begin
                    if (code == fcd_pkg::CODE_CONFIRM) begin
                        // Confirm latches address and data.
                        work_next = '{fcd_pkg::FCD_OP_FACTORY, addr_word,
                            pwdata[15:0]};
                        start_next = 1'b1;
                        state_next = FCD_FACTORY_MODE;
                        rs_next = fcd_pkg::FCD_RD_STATUS;
                    end else begin
                        sr_set = fcd_pkg::SR_SEQ_ERR;
                        rs_next = fcd_pkg::FCD_RD_STATUS;
                        state_next = FCD_IDLE;
                    end
                end
            end
            FCD_ERASE_SETUP: begin
                if (cmd_fire) begin
                    if (code == fcd_pkg::CODE_CONFIRM) begin
                        work_next = '{fcd_pkg::FCD_OP_ERASE, addr_word,
                            pwdata[15:0]};
                        start_next = 1'b1;
                        state_next = FCD_BUSY;
                    end else begin
                        sr_set = fcd_pkg::SR_SEQ_ERR;
                        state_next = FCD_IDLE;
                    end
                    rs_next = fcd_pkg::FCD_RD_STATUS;
                end
            end
            FCD_CFG_SETUP: begin
                if (cmd_fire) begin
                    state_next = FCD_IDLE;
                    unique case (code)
                        fcd_pkg::CODE_LOCK: begin
                            lock_we = blk_lock != fcd_pkg::LOCK_DOWN;
                            lock_wval = fcd_pkg::LOCK_LOCKED;
                        end
                        fcd_pkg::CODE_LOCK_DOWN: begin
                            lock_we = 1'b1;
                            lock_wval = fcd_pkg::LOCK_DOWN;
                        end
                        fcd_pkg::CODE_CONFIRM: begin
                            lock_we = blk_lock != fcd_pkg::LOCK_DOWN;
                            lock_wval = fcd_pkg::LOCK_OPEN;
                        end
                        fcd_pkg::CODE_SET_READ_SETUP: begin
                            rsr_next = cmd_addr_reg[15:0];
                            rs_next = fcd_pkg::FCD_RD_ARRAY;
                        end
                        default: begin
                            sr_set = fcd_pkg::SR_SEQ_ERR;
                            rs_next = fcd_pkg::FCD_RD_STATUS;
                        end
                    endcase
                end
            end
            FCD_PROT_SETUP: begin
                if (cmd_fire) begin
                    work_next = '{fcd_pkg::FCD_OP_PROT, addr_word,
                        pwdata[15:0]};
                    start_next = 1'b1;
                    state_next = FCD_BUSY;
                    rs_next = fcd_pkg::FCD_RD_STATUS;
                end
            end
            FCD_BUSY: begin
                if (wsm_done) begin
                    sr_set = wsm_err_bits & fcd_pkg::SR_ERR_MASK;
                    state_next = FCD_IDLE;
                end else if (cmd_fire) begin
                    if (code == fcd_pkg::CODE_READ_STATUS) begin
                        rs_next = fcd_pkg::FCD_RD_STATUS;
                    end else if (code == fcd_pkg::CODE_SUSPEND) begin
                        suspend_next = 1'b1;
                        state_next = FCD_SUSP_WAIT;
                    end
                end
            end
            FCD_SUSP_WAIT: begin
                if (wsm_done) begin
                    sr_set = wsm_err_bits & fcd_pkg::SR_ERR_MASK;
                    suspend_next = 1'b0;
                    state_next = FCD_IDLE;
                end else if (wsm_suspend_ack) begin
                    state_next = FCD_SUSPENDED;
                    sr_set[fcd_pkg::SR_ERASE_SUSP] =
                        work_reg.op == fcd_pkg::FCD_OP_ERASE;
                    sr_set[fcd_pkg::SR_PROG_SUSP] =
                        work_reg.op != fcd_pkg::FCD_OP_ERASE;
                end
                if (cmd_fire && code == fcd_pkg::CODE_READ_STATUS) begin
                    rs_next = fcd_pkg::FCD_RD_STATUS;
                end
            end
            FCD_SUSPENDED: begin
                // No pin or code other than confirm leaves this state; reset does.
                if (cmd_fire) begin
                    unique case (code)
                        fcd_pkg::CODE_CONFIRM: begin
                            suspend_next = 1'b0;
                            resume_next = 1'b1;
                            sr_clr[fcd_pkg::SR_ERASE_SUSP] = 1'b1;
                            sr_clr[fcd_pkg::SR_PROG_SUSP] = 1'b1;
                            state_next = FCD_BUSY;
                        end
                        fcd_pkg::CODE_READ_STATUS:
                            rs_next = fcd_pkg::FCD_RD_STATUS;
                        fcd_pkg::CODE_READ_ARRAY:
                            rs_next = fcd_pkg::FCD_RD_ARRAY;
                        fcd_pkg::CODE_READ_ID:
                            rs_next = fcd_pkg::FCD_RD_ID;
                        fcd_pkg::CODE_READ_QUERY:
                            rs_next = fcd_pkg::FCD_RD_QUERY;
                        fcd_pkg::CODE_CLEAR_STATUS:
                            sr_clr = fcd_pkg::SR_ERR_MASK;
                        default: ;
                    endcase
                end
            end
            FCD_FACTORY_MODE: begin
                // Command writes are data to the algorithm here.
                if (wsm_done) begin
                    sr_set = wsm_err_bits & fcd_pkg::SR_ERR_MASK;
                    state_next = FCD_IDLE;
                end
            end
            default: state_next = FCD_IDLE;
        endcase
    end

    // Set wins over clear; ready follows the next state.
    always_comb begin
        sr_next = (sr_reg & ~sr_clr) | sr_set;
        sr_next[fcd_pkg::SR_READY] = state_next != FCD_BUSY &&
            state_next != FCD_SUSP_WAIT &&
            state_next != FCD_FACTORY_MODE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= FCD_IDLE;
            rs_reg <= fcd_pkg::FCD_RD_ARRAY;
            work_reg <= '0;
            sr_reg <= fcd_pkg::SR_RESET;
            rsr_reg <= fcd_pkg::RSR_RESET;
            wsm_start <= 1'b0;
            suspend_reg <= 1'b0;
            wsm_resume <= 1'b0;
            factory_mode_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rs_reg <= rs_next;
            work_reg <= work_next;
            sr_reg <= sr_next;
            rsr_reg <= rsr_next;
            wsm_start <= start_next;
            suspend_reg <= suspend_next;
            wsm_resume <= resume_next;
            factory_mode_reg <= state_next == FCD_FACTORY_MODE;
        end
    end

    // Lock state per block; lock-down clears only through reset.
    for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_lock
        wire logic hit_blk = lock_we && blk == BLK_W'(b);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lock_reg[b] <= fcd_pkg::LOCK_RESET;
            end else if (hit_blk) begin
                lock_reg[b] <= lock_wval;
            end
        end
    end

    // Pin synchronisers; only the second stage and later are looked at.
    logic [2:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
    wire logic [2:0] pins = {address_valid_n, output_enable_n, chip_select_n};
    wire logic [2:0] pin_fall = pin_s3_reg & ~pin_s2_reg;
    wire logic async_rd = rsr_reg[fcd_pkg::RSR_ASYNC_BIT];
    wire logic refresh = pin_fall[0] |
        (async_rd ? pin_fall[1] : pin_fall[2]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 3'h7;
            pin_s2_reg <= 3'h7;
            pin_s3_reg <= 3'h7;
            status_out_reg <= fcd_pkg::SR_RESET;
        end else begin
            pin_s1_reg <= pins;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            if (refresh) begin
                status_out_reg <= sr_reg;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign wsm_work = work_reg;
    assign wsm_suspend = suspend_reg;
    assign read_state = rs_reg;
    assign status_out = status_out_reg;
    assign read_setup_register = rsr_reg;
    assign factory_mode = factory_mode_reg;

endmodule // fcd_command_decoder

// >>> tb/fcd_checker_sva.sv
/*
 * Concurrent checks on the command decoder's ports.
 * Assumes a single clock and the bind in the bench's top file.
 */
`timescale 1ns/1ps
module fcd_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic address_valid_n,
    input wire logic wsm_done,
    input wire logic wsm_start,
    input wire fcd_pkg::fcd_work_t wsm_work,
    input wire logic wsm_suspend,
    input wire logic wsm_resume,
    input wire fcd_pkg::fcd_read_state_t read_state,
    input wire logic [7:0] status_out,
    input wire logic factory_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] pin_q;
    wire logic [2:0] pins = {address_valid_n, output_enable_n,
        chip_select_n};
    logic [7:0] fell_hist;
    logic cmd_wr;
    assign cmd_wr = psel && penable && pwrite && pready
        && paddr == {24'h00, fcd_pkg::OFF_CMD_DATA};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 3'h7;
            fell_hist <= 8'h00;
        end else begin
            pin_q <= pins;
            fell_hist <= {fell_hist[6:0], |(pin_q & ~pins)};
        end
    end
    ready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    start_cause_a: assert property (wsm_start |-> $past(cmd_wr)
        && wsm_work.op != fcd_pkg::FCD_OP_NONE) else $error("stray start");
    erase_status_a: assert property (wsm_start
        && wsm_work.op == fcd_pkg::FCD_OP_ERASE
        |-> read_state == fcd_pkg::FCD_RD_STATUS) else $error("read state");
    factory_hold_a: assert property (factory_mode && !wsm_done
        |=> factory_mode) else $error("factory mode left early");
    factory_quiet_a: assert property (
        factory_mode && $past(factory_mode) |-> !wsm_start)
        else $error("start in factory mode");
    suspend_hold_a: assert property (wsm_suspend |=> wsm_suspend
        || wsm_resume || $past(wsm_done)) else $error("suspend dropped");
    suspend_cause_a: assert property ($rose(wsm_suspend) |->
        $past(cmd_wr && pwdata[7:0] == fcd_pkg::CODE_SUSPEND))
        else $error("suspend without its code");
    resume_cause_a: assert property (wsm_resume |->
        $past(cmd_wr && pwdata[7:0] == fcd_pkg::CODE_CONFIRM) ##1 !wsm_resume)
        else $error("bad resume pulse");
    status_refresh_a: assert property (!$stable(status_out)
        |-> |fell_hist) else $error("status output changed unprompted");
endmodule // fcd_checker

// >>> tb/fcd_engine_model.sv
/*
 * Behavioural write engine facing the decoder: runs for a set latency.
 * Assumes one start at a time and the decoder's suspend handshake.
 */
`timescale 1ns/1ps
module fcd_engine_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wsm_start,
    input wire logic wsm_suspend,
    input wire logic wsm_resume,
    input wire logic [7:0] latency,
    output logic wsm_done,
    output logic [7:0] wsm_err_bits,
    output logic wsm_suspend_ack
);
    logic [7:0] cnt_reg;
    logic busy_reg;
    logic held_reg;
    assign wsm_err_bits = 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            busy_reg <= 1'b0;
            held_reg <= 1'b0;
            wsm_done <= 1'b0;
            wsm_suspend_ack <= 1'b0;
        end else begin
            wsm_done <= 1'b0;
            wsm_suspend_ack <= 1'b0;
            if (wsm_start) begin
                busy_reg <= 1'b1;
                cnt_reg <= latency;
            end else if (wsm_resume) begin
                held_reg <= 1'b0;
            end else if (busy_reg && wsm_suspend && !held_reg) begin
                held_reg <= 1'b1;
                wsm_suspend_ack <= 1'b1;
            end else if (busy_reg && !held_reg) begin
                busy_reg <= cnt_reg != 8'h00;
                wsm_done <= cnt_reg == 8'h00;
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule // fcd_engine_model

// >>> tb/flash_command_decoder_bench.sv
/*
 * Self-checking bench: command cycles over APB, register reads.
 * Assumes the engine model answers the decoder's work requests.
 */
`timescale 1ns/1ps
module flash_command_decoder_bench;
    logic pclk, presetn, psel, penable, pwrite, cs_n, pready, pslverr, err;
    logic done, ack, start, susp, res, fmode, oe_n, adv_n;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [7:0] lat, errb, sout;
    logic [15:0] rsr;
    fcd_pkg::fcd_work_t work, last;
    fcd_pkg::fcd_read_state_t rs;
    int num_errors, checked, starts;
    logic [15:0] lk_code [5] = '{16'hD0, 16'h01, 16'h2F, 16'hD0, 16'h55};
    logic [31:0] lk_exp [5] = '{32'h0, 32'h1, 32'h3, 32'h3, 32'h3};
    fcd_command_decoder i_fcd_command_decoder (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chip_select_n(cs_n), .output_enable_n(oe_n),
        .address_valid_n(adv_n), .wsm_done(done), .wsm_err_bits(errb),
        .wsm_suspend_ack(ack), .wsm_work(work), .wsm_start(start),
        .wsm_suspend(susp), .wsm_resume(res), .read_state(rs),
        .status_out(sout), .read_setup_register(rsr), .factory_mode(fmode));
    fcd_engine_model i_fcd_engine_model (.pclk(pclk), .presetn(presetn),
        .wsm_start(start), .wsm_suspend(susp), .wsm_resume(res),
        .latency(lat), .wsm_done(done), .wsm_err_bits(errb),
        .wsm_suspend_ack(ack));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (start === 1'b1) begin
            starts <= starts + 1;
            last <= work;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h00, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [31:0] a, input logic [15:0] d);
        bus(1'b1, fcd_pkg::OFF_CMD_ADDR, a);
        bus(1'b1, fcd_pkg::OFF_CMD_DATA, {16'h0000, d});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            bus(1'b0, fcd_pkg::OFF_STATUS, 32'h0);
            n++;
        end while (rd[7] !== 1'b1 && n < 100);
        if (rd[7] !== 1'b1) begin
            num_errors++;
            end_of_test();
        end
    endtask
    task automatic rs_is(input fcd_pkg::fcd_read_state_t e);
        @(posedge pclk);
        check({30'h0, rs}, {30'h0, e});
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cs_n, oe_n, adv_n} = 3'h7;
        lat = 8'h04;
        num_errors = 0;
        checked = 0;
        starts = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rchk(fcd_pkg::OFF_STATUS, 32'h80);
        rchk(fcd_pkg::OFF_READ_SETUP, 32'hBFCF);
        rchk(fcd_pkg::OFF_LOCK, 32'h1);
        rchk(8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            cmd(32'h30000, 16'h60);
            cmd(32'h30000, lk_code[i]);
            rchk(fcd_pkg::OFF_LOCK, lk_exp[i]);
        end
        rchk(fcd_pkg::OFF_STATUS, 32'hB0);
        check({24'h0, sout}, 32'h80);
        cs_n <= 1'b0;
        repeat (2) @(posedge pclk);
        cs_n <= 1'b1;
        repeat (8) @(posedge pclk);
        check({24'h0, sout}, 32'hB0);
        cmd(32'h0, 16'h50);
        rchk(fcd_pkg::OFF_STATUS, 32'h80);
        oe_n <= 1'b0;
        repeat (6) @(posedge pclk);
        check({24'h0, sout}, 32'h80);
        cmd(32'h1234, 16'h70);
        rs_is(fcd_pkg::FCD_RD_STATUS);
        cmd(32'h1234, 16'h60);
        cmd(32'h1234, 16'h03);
        rs_is(fcd_pkg::FCD_RD_ARRAY);
        rchk(fcd_pkg::OFF_READ_SETUP, 32'h1234);
        cmd(32'h20000, 16'h70);
        cmd(32'h20000, 16'hFF);
        rs_is(fcd_pkg::FCD_RD_ARRAY);
        cmd(32'h20000, 16'h60);
        cmd(32'h20000, 16'hD0);
        lat <= 8'd80;
        cmd(32'h20000, 16'h20);
        cmd(32'h20000, 16'hD0);
        rchk(fcd_pkg::OFF_STATUS, 32'h00);
        check(last.addr, 32'h20000);
        adv_n <= 1'b0;
        repeat (6) @(posedge pclk);
        check({24'h0, sout}, 32'h00);
        cmd(32'h20000, 16'h60);
        cmd(32'h20000, 16'h01);
        rchk(fcd_pkg::OFF_LOCK, 32'h0);
        cmd(32'h0, 16'hB0);
        repeat (4) @(posedge pclk);
        rchk(fcd_pkg::OFF_STATUS, 32'hC0);
        repeat (50) @(posedge pclk);
        rchk(fcd_pkg::OFF_STATUS, 32'hC0);
        cmd(32'h0, 16'hD0);
        rchk(fcd_pkg::OFF_STATUS, 32'h00);
        wait_ready();
        cmd(32'h20000, 16'h20);
        cmd(32'h20000, 16'hFF);
        rchk(fcd_pkg::OFF_STATUS, 32'hB0);
        check({30'h0, rs}, {30'h0, fcd_pkg::FCD_RD_STATUS});
        check(starts, 1);
        cmd(32'h0, 16'h50);
        lat <= 8'd60;
        cmd(32'h40000, 16'h80);
        cmd(32'h40000, 16'h12D0);
        repeat (2) @(posedge pclk);
        check({30'h0, last.op}, 32'h2);
        check(last.addr, 32'h40000);
        check({16'h0, last.data}, 32'h12D0);
        check({31'h0, fmode}, 32'h1);
        cmd(32'h20000, 16'h20);
        cmd(32'h20000, 16'hD0);
        check(starts, 2);
        wait_ready();
        lat <= 8'h04;
        cmd(32'h80, 16'hC0);
        cmd(32'h80, 16'h5678);
        repeat (2) @(posedge pclk);
        check({30'h0, last.op}, 32'h3);
        check(last.addr, 32'h80);
        check({16'h0, last.data}, 32'h5678);
        wait_ready();
        end_of_test();
    end
endmodule // flash_command_decoder_bench
bind fcd_command_decoder fcd_checker i_fcd_checker (.*);
